// *** core/rips_pkg.sv ***
// Package for the reference input prescaler and select block.
// Assumes a single 10 MHz system clock and a plain register port.
package rips_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] TEST_CTRL_ONE_ADDR = 8'h03;
    localparam logic [7:0] REF_FREQ_BASE_ADDR = 8'h20;
    localparam logic [7:0] REF_FREQ_LAST_ADDR = 8'h2d;
    localparam logic [7:0] INPUT_MODE_ADDR = 8'h34;
    localparam logic [7:0] DIFF_INPUT_ADDR = 8'h35;
    localparam logic [7:0] DIVIDER_N_LOW_ADDR = 8'h46;
    localparam logic [7:0] DIVIDER_N_HIGH_ADDR = 8'h47;
    localparam logic [7:0] SEL_INPUT_ADDR = 8'h50;
    localparam logic [7:0] STATUS_ADDR = 8'h51;
    localparam logic [7:0] PRIO_BASE_ADDR = 8'h60;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int NETWORK_TYPE_POS = 2;
    localparam int EDGE_POL_POS = 2;
    localparam int AUTO_LOCK_POS = 6;
    localparam int DIV_MODE_POS = 7;

    // ****************************************************************
    // Sizes, limits and reset values
    // ****************************************************************
    localparam int NUM_INPUTS = 14;
    localparam int N_WIDTH = 14;
    localparam logic [13:0] N_MIN = 14'h0001;
    localparam logic [13:0] N_MAX = 14'h30d3;
    localparam logic [7:0] REF_FREQ_RST = 8'h00;
    localparam logic [13:0] DIVIDER_N_RST = 14'h0001;
    localparam logic [7:0] DIFF_INPUT_RST = 8'h01;
    localparam logic [3:0] PRIO_I11_MASTER = 4'hc;
    localparam logic [3:0] PRIO_I11_SLAVE = 4'h1;
    localparam int I11_INDEX = 10;

    // Frequency codes in the low nibble of each frequency register
    localparam logic [3:0] FREQ_8K = 4'h0;
    localparam logic [3:0] FREQ_1544K = 4'h1;
    localparam logic [3:0] FREQ_2048K = 4'h2;
    localparam logic [3:0] FREQ_6480K = 4'h4;
    localparam logic [3:0] FREQ_19440K = 4'h5;
    localparam logic [3:0] FREQ_77760K = 4'h8;
    localparam logic [3:0] FREQ_155520K = 4'h9;
    localparam logic [3:0] FREQ_64_8K = 4'ha;
    localparam logic [3:0] FREQ_2K = 4'hb;
    localparam logic [3:0] FREQ_4K = 4'hc;

    // Locking frequency modes
    typedef enum logic [1:0] {
        RIPS_DIRECT,
        RIPS_AUTO8K,
        RIPS_DIVIDE_BY_COUNT_MODE
    } rips_mode_t;

endpackage

// *** core/rips_top.sv ***
// Reference input prescaler and select: registers, defaults and divider.
// Assumes ref_clk_i pins are asynchronous and much slower than clk_i.
// What this block does
// - Mode register bit two picks network type
// - Reset loads network type from pin
// - Fourteen frequency registers at 20 to 2D
// - Direct lock compares at input frequency
// - Eight kHz and divide modes prescale input
// - Bit six auto divides down to 8k, but passes 155 MHz undivided
// - Test register bit two picks edge in 8k mode
// - Bit seven uses programmed N divider
// - Divider ratio is N plus one
// - One N shared by all inputs
// - N held in registers 46 and 47
// - 155 MHz direct lock divides by two
// - Differential register picks PECL or LVDS
// - Composite clock violations are detected
// - Channel codes 0001 to 1110 by port
// - Default priorities rise two to fifteen
// - Input eleven priority from master pin
// - Default frequencies depend on port, network
// - Spot frequencies accepted per input kind
// - Four or eight kHz sync accepted
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module rips_top
    import rips_pkg::*;
#(
    parameter int NUM_IN = 14
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic network_type_pin_i,
    input wire logic master_slave_select_pin_i,
    input wire logic [13:0] ref_clk_i,
    input wire logic cc_pos_i,
    input wire logic cc_neg_i,
    output logic compare_pulse_o,
    output logic [3:0] sel_channel_o,
    output logic [1:0] sel_mode_o,
    output logic [1:0] diff_lvds_o,
    output logic cc_violation_err_o
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [13:0] ref_s1_q;
    logic [13:0] ref_s2_q;
    logic [13:0] ref_s3_q;
    logic cc_pos_s1_q, cc_pos_s2_q, cc_pos_s3_q;
    logic cc_neg_s1_q, cc_neg_s2_q, cc_neg_s3_q;
    logic strap_net_s1_q, strap_net_s2_q;
    logic strap_ms_s1_q, strap_ms_s2_q;

    // Two flops per pin; the third only feeds edge detection
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ref_s1_q <= '0;
            ref_s2_q <= '0;
            ref_s3_q <= '0;
            cc_pos_s1_q <= 1'b0;
            cc_pos_s2_q <= 1'b0;
            cc_pos_s3_q <= 1'b0;
            cc_neg_s1_q <= 1'b0;
            cc_neg_s2_q <= 1'b0;
            cc_neg_s3_q <= 1'b0;
        end else begin
            ref_s1_q <= ref_clk_i;
            ref_s2_q <= ref_s1_q;
            ref_s3_q <= ref_s2_q;
            cc_pos_s1_q <= cc_pos_i;
            cc_pos_s2_q <= cc_pos_s1_q;
            cc_pos_s3_q <= cc_pos_s2_q;
            cc_neg_s1_q <= cc_neg_i;
            cc_neg_s2_q <= cc_neg_s1_q;
            cc_neg_s3_q <= cc_neg_s2_q;
        end
    end

    // Straps keep sampling during reset so the loaded value is current
    always_ff @(posedge clk_i) begin
        strap_net_s1_q <= network_type_pin_i;
        strap_net_s2_q <= strap_net_s1_q;
        strap_ms_s1_q <= master_slave_select_pin_i;
        strap_ms_s2_q <= strap_ms_s1_q;
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [7:0] test_ctrl_q;
    logic [7:0] input_mode_q;
    logic [7:0] diff_cfg_q;
    logic [13:0] div_n_q;
    logic [3:0] sel_idx_q;
    logic [7:0] ref_freq_q [NUM_IN];
    logic [3:0] prio_q [NUM_IN];
    logic reset_seen_q;
    logic cfg_change;
    logic [7:0] rdata_d;

    // Default frequency code per port, network type and role
    function automatic logic [3:0] dflt_freq(input int idx, input logic sonet,
                                             input logic master);
        logic [3:0] tele;
        tele = sonet ? FREQ_1544K : FREQ_2048K;
        if (idx < 2) dflt_freq = FREQ_64_8K;
        else if (idx < 4) dflt_freq = FREQ_8K;
        else if (idx < I11_INDEX) dflt_freq = FREQ_19440K;
        else if (idx == I11_INDEX && !master) dflt_freq = FREQ_6480K;
        else dflt_freq = tele;
    endfunction

    // Four-bit channel code of a port, 0001 for the first
    function automatic logic [3:0] chan_code(input logic [3:0] idx);
        chan_code = idx + 4'h1;
    endfunction

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            reset_seen_q <= 1'b1;
            test_ctrl_q <= '0;
            input_mode_q <= '0;
            diff_cfg_q <= DIFF_INPUT_RST;
            div_n_q <= DIVIDER_N_RST;
            sel_idx_q <= '0;
            for (int i = 0; i < NUM_IN; i++) begin
                ref_freq_q[i] <= REF_FREQ_RST;
                prio_q[i] <= 4'(i + 2);
            end
        end else if (reset_seen_q) begin
            // First cycle after release: straps taken by a clocked load
            reset_seen_q <= 1'b0;
            input_mode_q[NETWORK_TYPE_POS] <= strap_net_s2_q;
            for (int i = 0; i < NUM_IN; i++) begin
                ref_freq_q[i] <= {4'h0, dflt_freq(i, strap_net_s2_q, strap_ms_s2_q)};
            end
            prio_q[I11_INDEX] <= strap_ms_s2_q ? PRIO_I11_MASTER : PRIO_I11_SLAVE;
        end else if (wr_i) begin
            if (addr_i == INPUT_MODE_ADDR) input_mode_q <= wdata_i;
            if (addr_i == TEST_CTRL_ONE_ADDR) test_ctrl_q <= wdata_i;
            if (addr_i == DIFF_INPUT_ADDR) diff_cfg_q <= wdata_i;
            // N held in a byte pair
            if (addr_i == DIVIDER_N_LOW_ADDR) div_n_q[7:0] <= wdata_i;
            if (addr_i == DIVIDER_N_HIGH_ADDR) div_n_q[13:8] <= wdata_i[5:0];
            // Out of range index ignored, so lane pick never reads X
            if (addr_i == SEL_INPUT_ADDR && wdata_i[3:0] < 4'(NUM_IN)) sel_idx_q <= wdata_i[3:0];
            for (int i = 0; i < NUM_IN; i++) begin
                if (addr_i == REF_FREQ_BASE_ADDR + 8'(i)) ref_freq_q[i] <= wdata_i;
                if (addr_i == PRIO_BASE_ADDR + 8'(i)) prio_q[i] <= wdata_i[3:0];
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = '0;
        if (addr_i == TEST_CTRL_ONE_ADDR) rdata_d = test_ctrl_q;
        if (addr_i == INPUT_MODE_ADDR) rdata_d = input_mode_q;
        if (addr_i == DIFF_INPUT_ADDR) rdata_d = diff_cfg_q;
        if (addr_i == DIVIDER_N_LOW_ADDR) rdata_d = div_n_q[7:0];
        if (addr_i == DIVIDER_N_HIGH_ADDR) rdata_d = {2'b00, div_n_q[13:8]};
        if (addr_i == SEL_INPUT_ADDR) rdata_d = {4'h0, sel_idx_q};
        if (addr_i == STATUS_ADDR) rdata_d = {5'h0, cc_violation_err_o, sel_mode_o};
        for (int i = 0; i < NUM_IN; i++) begin
            if (addr_i == REF_FREQ_BASE_ADDR + 8'(i)) rdata_d = ref_freq_q[i];
            if (addr_i == PRIO_BASE_ADDR + 8'(i)) rdata_d = {4'h0, prio_q[i]};
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!resetn_i) rdata_o <= '0;
        else rdata_o <= rd_i ? rdata_d : 8'h00;
    end

    // ****************************************************************
    // Mode decode for the selected input
    // ****************************************************************
    rips_mode_t mode;
    logic [7:0] sel_cfg;
    logic sel_edge;
    logic [13:0] div_ratio_m1;
    logic [1:0] mode_q;
    logic [13:0] div_n_seen_q;

    assign sel_cfg = ref_freq_q[sel_idx_q];

    // manual N wins over automatic 8k
    // one N value shared by all
    always_comb begin
        if (sel_cfg[DIV_MODE_POS]) begin
            mode = RIPS_DIVIDE_BY_COUNT_MODE;
            div_ratio_m1 = div_n_q;
        end else if (sel_cfg[AUTO_LOCK_POS]) begin
            mode = RIPS_AUTO8K;
            case (sel_cfg[3:0])
                FREQ_2K, FREQ_4K, FREQ_8K: div_ratio_m1 = '0;
                FREQ_1544K: div_ratio_m1 = 14'd192;
                FREQ_2048K: div_ratio_m1 = 14'd255;
                FREQ_6480K: div_ratio_m1 = 14'd809;
                FREQ_19440K: div_ratio_m1 = 14'd2429;
                FREQ_77760K: div_ratio_m1 = 14'd9719;
                FREQ_64_8K: div_ratio_m1 = 14'd7;
                default: div_ratio_m1 = '0;
            endcase
        end else begin
            mode = RIPS_DIRECT;
            div_ratio_m1 = (sel_cfg[3:0] == FREQ_155520K) ? 14'd1 : 14'd0;
        end
    end

    // Edge polarity applies only to 8k locking; direct lock uses rising
    assign sel_edge = (mode == RIPS_AUTO8K) && test_ctrl_q[EDGE_POL_POS];

    // ****************************************************************
    // Prescaler
    // ****************************************************************
    logic ref_now, ref_old, ref_edge;
    logic [13:0] div_cnt_q;

    assign ref_now = ref_s2_q[sel_idx_q];
    assign ref_old = ref_s3_q[sel_idx_q];
    assign ref_edge = sel_edge ? (ref_old & ~ref_now) : (~ref_old & ref_now);
    assign cfg_change = (2'(mode) != mode_q) || (div_n_seen_q != div_ratio_m1);

    // restart on mode or N change
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            mode_q <= '0;
            div_n_seen_q <= '0;
        end else begin
            mode_q <= 2'(mode);
            div_n_seen_q <= div_ratio_m1;
        end
    end

    // one event every N plus one
    always_ff @(posedge clk_i) begin
        if (!resetn_i || cfg_change) begin
            div_cnt_q <= '0;
            compare_pulse_o <= 1'b0;
        end else if (ref_edge) begin
            if (div_cnt_q >= div_ratio_m1) begin
                div_cnt_q <= '0;
                compare_pulse_o <= 1'b1;
            end else begin
                div_cnt_q <= div_cnt_q + 14'd1;
                compare_pulse_o <= 1'b0;
            end
        end else begin
            compare_pulse_o <= 1'b0;
        end
    end

    assign sel_channel_o = chan_code(sel_idx_q);
    assign sel_mode_o = mode_q;
    assign diff_lvds_o = diff_cfg_q[1:0];

    // ****************************************************************
    // Composite clock violation check
    // ****************************************************************
    logic last_pol_q;
    logic [3:0] mark_cnt_q;
    logic cc_mark, cc_pol;

    assign cc_mark = (cc_pos_s2_q & ~cc_pos_s3_q) | (cc_neg_s2_q & ~cc_neg_s3_q);
    assign cc_pol = cc_pos_s2_q;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            last_pol_q <= 1'b0;
            mark_cnt_q <= '0;
            cc_violation_err_o <= 1'b0;
        end else if (cc_mark) begin
            last_pol_q <= cc_pol;
            if (cc_pol == last_pol_q) begin
                cc_violation_err_o <= (mark_cnt_q != 4'd7);
                mark_cnt_q <= '0;
            end else begin
                cc_violation_err_o <= (mark_cnt_q >= 4'd8);
                // Saturate so a long clean run keeps the flag raised
                if (mark_cnt_q != 4'hf) mark_cnt_q <= mark_cnt_q + 4'd1;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // pulse only on an edge
    pulse_on_edge_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        compare_pulse_o |-> $past(ref_edge)) else $error("pulse without edge");
    restart_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $past(cfg_change) |-> div_cnt_q == 14'd0) else $error("no restart");
    direct_pass_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (mode == RIPS_DIRECT && div_ratio_m1 == 0 && ref_edge && !cfg_change)
        |=> compare_pulse_o) else $error("direct edge lost");
    divide_by_count_mode_sel_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        sel_cfg[DIV_MODE_POS] |-> (div_ratio_m1 == div_n_q) ##1 (sel_mode_o == 2'(RIPS_DIVIDE_BY_COUNT_MODE)))
        else $error("N not used");
    half_rate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (sel_cfg[7:6] == 2'b00 && sel_cfg[3:0] == FREQ_155520K) |-> div_ratio_m1 == 14'd1)
        else $error("155 not halved");
    i11_prio_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        reset_seen_q ##1 !$past(wr_i) |->
        prio_q[I11_INDEX] == ($past(strap_ms_s2_q) ? PRIO_I11_MASTER : PRIO_I11_SLAVE))
        else $error("wrong i11 priority");
    strap_load_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        reset_seen_q |=> input_mode_q[NETWORK_TYPE_POS] == $past(strap_net_s2_q))
        else $error("strap not loaded");
    chan_code_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        sel_channel_o == sel_idx_q + 4'h1) else $error("bad channel code");
    n_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (wr_i && !reset_seen_q && addr_i == DIVIDER_N_HIGH_ADDR)
        |=> div_n_q[13:8] == $past(wdata_i[5:0])) else $error("N high lost");
    mode_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (wr_i && !reset_seen_q && addr_i == INPUT_MODE_ADDR)
        |=> input_mode_q[NETWORK_TYPE_POS] == $past(wdata_i[NETWORK_TYPE_POS]))
        else $error("network type write lost");
    cnt_bound_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !cfg_change |-> div_cnt_q <= div_ratio_m1) else $error("divider overrun");
    err_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !cc_mark |=> $stable(cc_violation_err_o)) else $error("flag moved without mark");
    viol_ok_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (cc_mark && cc_pol == last_pol_q && mark_cnt_q == 4'd7) |=> !cc_violation_err_o)
        else $error("good boundary flagged");
    prescale_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (mode != RIPS_DIRECT && ref_edge && div_cnt_q < div_ratio_m1) |=> !compare_pulse_o)
        else $error("prescaler leaked edge");
    freq_dflt_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        reset_seen_q |=> ref_freq_q[NUM_IN - 1][3:0] ==
        ($past(strap_net_s2_q) ? FREQ_1544K : FREQ_2048K)) else $error("wrong line default");

    divide_by_count_mode_cov: cover property (@(posedge clk_i) mode == RIPS_DIVIDE_BY_COUNT_MODE ##[1:1000] compare_pulse_o);
    auto_cov: cover property (@(posedge clk_i) mode == RIPS_AUTO8K && compare_pulse_o);
    viol_cov: cover property (@(posedge clk_i) cc_violation_err_o);
    half_cov: cover property (@(posedge clk_i) mode == RIPS_DIRECT && div_ratio_m1 == 14'd1 && compare_pulse_o);

endmodule

// *** tb/rips_ref_src.sv ***
// Model of the reference clock sources feeding the fourteen inputs.
// Assumes the bench drives one lane at a time; link period is 800 ns.
`timescale 1ns/100ps
module rips_ref_src (
    output logic [13:0] ref_clk_o,
    output logic cc_pos_o,
    output logic cc_neg_o
);
    // ****************************************************************
    // Idle levels
    // ****************************************************************
    // Lines rest low between bursts, so no stray edge reaches the prescaler
    initial begin
        ref_clk_o = 14'h0000;
        cc_pos_o = 1'b0;
        cc_neg_o = 1'b0;
    end

    // one shared rate
    // Only the chosen lane toggles, so every divided lane runs at one rate
    task automatic burst(input int idx, input int edges);
        // Start off the clock edge so the pin never races the sampling flop
        #20;
        for (int e = 0; e < edges; e++) begin
            ref_clk_o[idx] = 1'b1;
            #400;
            ref_clk_o[idx] = 1'b0;
            #400;
        end
    endtask

    // Static level, used to show which edge is taken
    task automatic level(input int idx, input logic val);
        #20;
        ref_clk_o[idx] = val;
    endtask

    // Plain alternating marks with no boundary violation at all
    task automatic marks(input int n);
        #20;
        for (int m = 0; m < n; m++) begin
            if (m % 2 == 1) cc_pos_o = 1'b1;
            else cc_neg_o = 1'b1;
            #200;
            cc_pos_o = 1'b0;
            cc_neg_o = 1'b0;
            #200;
        end
    endtask

    // Composite frames: alternating marks, every eighth repeats polarity
    task automatic framed(input int n);
        logic p;
        p = 1'b0;
        #20;
        for (int m = 0; m < n; m++) begin
            if (m % 8 != 0) p = ~p;
            if (p) cc_pos_o = 1'b1;
            else cc_neg_o = 1'b1;
            #200;
            cc_pos_o = 1'b0;
            cc_neg_o = 1'b0;
            #200;
        end
    endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the reference prescaler and select block.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/100ps
module tb_top;
    import rips_pkg::*;
    `define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fails++; \
        $display("Error at %0t: got %h expected %h", $time, got, exp); end end

    logic clk = 1'b0, resetn = 1'b0, wr_s = 1'b0, rd_s = 1'b0, netpin = 1'b1, mspin = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r;
    logic [13:0] ref_clk;
    logic cc_pos, cc_neg, pulse, cc_err;
    logic [3:0] chan;
    logic [1:0] mode, lvds;
    int fails = 0, check_count = 0, pulses = 0;

    // Link scenarios: config byte, lane, N, edges sent, pulses expected, mode
    logic [7:0] cfg_t [7] = '{8'h05, 8'h09, 8'h40, 8'h4a, 8'h80, 8'hb0, 8'hc0};
    int idx_t [7] = '{4, 5, 2, 3, 2, 13, 7};
    int n_t [7] = '{3, 3, 3, 3, 3, 1, 3};
    int ed_t [7] = '{12, 12, 12, 16, 12, 12, 12};
    int exp_t [7] = '{12, 6, 12, 2, 3, 6, 3};
    logic [1:0] md_t [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};

    rips_top uut (.clk_i(clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .network_type_pin_i(netpin),
        .master_slave_select_pin_i(mspin), .ref_clk_i(ref_clk), .cc_pos_i(cc_pos),
        .cc_neg_i(cc_neg), .compare_pulse_o(pulse), .sel_channel_o(chan),
        .sel_mode_o(mode), .diff_lvds_o(lvds), .cc_violation_err_o(cc_err));
    rips_ref_src partner (.ref_clk_o(ref_clk), .cc_pos_o(cc_pos), .cc_neg_o(cc_neg));

    // ****************************************************************
    // Clock, pulse counter, bus tasks
    // ****************************************************************
    initial begin
        forever #50 clk = ~clk;
    end

    // Pulse is one cycle wide, so one count per clock is exact
    always @(posedge clk) begin
        // An unknown pulse counts too, so it cannot hide behind zero
        if (pulse !== 1'b0) pulses++;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    // Data is sampled after the answering edge has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic do_reset(input logic son, input logic mst);
        @(posedge clk);
        resetn <= 1'b0;
        netpin <= son;
        mspin <= mst;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
    endtask

    function automatic logic [3:0] expf(int i, logic son, logic mst);
        if (i < 2) return FREQ_64_8K;
        if (i < 4) return FREQ_8K;
        if (i < 10) return FREQ_19440K;
        if (i == I11_INDEX && !mst) return FREQ_6480K;
        return son ? FREQ_1544K : FREQ_2048K;
    endfunction

    // Strap-driven defaults for both networks and both roles
    task automatic chk_defaults(input logic son, input logic mst);
        logic [3:0] p;
        do_reset(son, mst);
        rd(INPUT_MODE_ADDR, r);
        `CHK(r[NETWORK_TYPE_POS], son)
        for (int i = 0; i < NUM_INPUTS; i++) begin
            rd(REF_FREQ_BASE_ADDR + 8'(i), r);
            `CHK(r[3:0], expf(i, son, mst))
            p = (i == I11_INDEX) ? (mst ? PRIO_I11_MASTER : PRIO_I11_SLAVE) : 4'(i + 2);
            rd(PRIO_BASE_ADDR + 8'(i), r);
            `CHK(r[3:0], p)
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Whole run is near 1400 cycles; allow a wide margin
    initial begin
        #5000000;
        fails++;
        summarize();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        chk_defaults(1'b0, 1'b0);
        chk_defaults(1'b1, 1'b1);
        `CHK(lvds, 2'b01)
        `CHK(cc_err, 1'b0)
        wr(INPUT_MODE_ADDR, 8'h00);
        rd(INPUT_MODE_ADDR, r);
        `CHK(r[NETWORK_TYPE_POS], 1'b0)
        wr(DIFF_INPUT_ADDR, 8'h02);
        wr(DIVIDER_N_LOW_ADDR, 8'hf9);
        wr(DIVIDER_N_HIGH_ADDR, 8'hff);
        `CHK(lvds, 2'b10)
        rd(DIVIDER_N_LOW_ADDR, r);
        `CHK(r, 8'hf9)
        rd(DIVIDER_N_HIGH_ADDR, r);
        `CHK(r, 8'h3f)
        @(posedge clk);
        #1 `CHK(rdata, 8'h00)
        rd(8'h7f, r);
        `CHK(r, 8'h00)
        for (int i = 0; i < NUM_INPUTS; i++) begin
            wr(SEL_INPUT_ADDR, 8'(i));
            @(posedge clk);
            `CHK(chan, 4'(i + 1))
        end
        // Each mode, dividing by one, two, four and eight, counted edge by edge
        for (int i = 0; i < 7; i++) begin
            wr(TEST_CTRL_ONE_ADDR, 8'h00);
            wr(DIVIDER_N_LOW_ADDR, 8'(n_t[i]));
            wr(DIVIDER_N_HIGH_ADDR, 8'h00);
            wr(REF_FREQ_BASE_ADDR + 8'(idx_t[i]), cfg_t[i]);
            wr(SEL_INPUT_ADDR, 8'(idx_t[i]));
            repeat (4) @(posedge clk);
            pulses = 0;
            partner.burst(idx_t[i], ed_t[i]);
            repeat (10) @(posedge clk);
            `CHK(pulses, exp_t[i])
            `CHK(mode, md_t[i])
        end
        // A new N mid-count restarts the divider; lane 2 is in divide mode
        wr(SEL_INPUT_ADDR, 8'h02);
        wr(DIVIDER_N_LOW_ADDR, 8'h03);
        repeat (4) @(posedge clk);
        partner.burst(2, 2);
        wr(DIVIDER_N_LOW_ADDR, 8'h02);
        repeat (4) @(posedge clk);
        pulses = 0;
        partner.burst(2, 5);
        repeat (10) @(posedge clk);
        `CHK(pulses, 1)
        // Edge choice for eight kHz locking: falling, then rising
        wr(REF_FREQ_BASE_ADDR + 8'h02, 8'h40);
        wr(TEST_CTRL_ONE_ADDR, 8'h04);
        repeat (4) @(posedge clk);
        pulses = 0;
        partner.level(2, 1'b1);
        repeat (20) @(posedge clk);
        `CHK(pulses, 0)
        partner.level(2, 1'b0);
        repeat (20) @(posedge clk);
        `CHK(pulses, 1)
        wr(TEST_CTRL_ONE_ADDR, 8'h00);
        repeat (4) @(posedge clk);
        pulses = 0;
        partner.level(2, 1'b1);
        repeat (20) @(posedge clk);
        `CHK(pulses, 1)
        partner.level(2, 1'b0);
        // Sixteen marks with no violation must be flagged
        partner.marks(16);
        repeat (10) @(posedge clk);
        `CHK(cc_err, 1'b1)
        rd(STATUS_ADDR, r);
        `CHK(r[2], 1'b1)
        // Proper frames: a violation on every eighth mark clears the flag
        partner.framed(24);
        repeat (10) @(posedge clk);
        `CHK(cc_err, 1'b0)
        summarize();
    end
endmodule
